//--- design/cpa_driver.sv
/*
  Driver end: answers the scanner's output image with the input image,
  keeps a small parameter store, four monitor slots and the stored-data
  start/ready handshake. Assumes the scanner image is synchronous to mclk.
  The remote command word comes from logic on the same clock and uses the
  bit layout of the fixed output word. Only ids 0 to 0xFFF are valid; ids
  0x100 to 0x103 hold the monitor addresses, the entry-1 ids hold type and
  position, and every other valid id reads back as itself. The run is a
  fixed count of cycles, not a motion profile; speed and acceleration are
  left to the logic that consumes the run outputs.
*/
`timescale 1ns/1ps
module cpa_driver (
  input wire logic mclk,
  input wire logic rst_b,
  cpa_if.driver img,
  input wire cpa_pkg::cpa_word_t remote_cmd,
  output logic energised,
  output logic running,
  output logic direct_run,
  output cpa_pkg::cpa_word_t run_data_num,
  output cpa_pkg::cpa_dword_t run_target
);
  import cpa_pkg::*;

  typedef struct packed {
    cpa_word_t fixed_out;
    cpa_word_t rd_echo;
    cpa_word_t status;
    cpa_word_t wr_echo;
    cpa_dword_t rd_data;
    cpa_mon_t mon;
    logic req_prev;
    logic start_prev;
    cpa_dword_t op_type1;
    cpa_dword_t pos1;
    cpa_word_t [3:0] mon_addr;
    logic [7:0] run_cnt;
    logic energised;
    logic running;
    logic direct_run;
    cpa_word_t run_num;
    cpa_dword_t run_target;
  } cpa_drv_s;

  cpa_drv_s st_q, st_d;

  function automatic logic id_ok(input cpa_word_t id);
    id_ok = (id <= CPA_ID_MAX);
  endfunction

  // Four monitor-address ids; upper bound kept exclusive
  function automatic logic is_mon_id(input cpa_word_t id);
    is_mon_id = (id >= CPA_ID_MONADDR0) &&
                (id < CPA_ID_MONADDR0 + 16'h0004);
  endfunction

  // Unmapped ids read back as their own id, zero-extended
  function automatic cpa_dword_t param_rd(input cpa_drv_s s,
                                         input cpa_word_t id);
    cpa_dword_t v;
    v = {CPA_RST_ZERO16, id};
    if (id == CPA_ID_OP_TYPE1) begin
      v = s.op_type1;
    end else if (id == CPA_ID_POS1) begin
      v = s.pos1;
    end else if (is_mon_id(id)) begin
      v = {CPA_RST_ZERO16, s.mon_addr[id[1:0]]};
    end
    param_rd = v;
  endfunction

  logic req_now;
  logic start_now;
  logic direct_now;
  logic direct_rem;
  logic fwd_fixed;
  logic start_rem;
  logic fwd_rem;
  logic start_any;
  logic any_fixed;
  logic any_rem;
  logic conflict;

  always_comb begin
    st_d = st_q;
    req_now = img.out_wr_req[CPA_BIT_WR_REQ];
    start_now = img.out_fixed[CPA_BIT_START];
    direct_now = img.out_fixed[CPA_BIT_DIRECT];
    fwd_fixed = img.out_fixed[CPA_BIT_FWD];
    start_rem = remote_cmd[CPA_BIT_START];
    direct_rem = remote_cmd[CPA_BIT_DIRECT];
    fwd_rem = remote_cmd[CPA_BIT_FWD];
    start_any = start_now | start_rem;
    any_fixed = start_now | fwd_fixed;
    any_rem = start_rem | fwd_rem;
    // One word alone never conflicts; both must ask at once
    conflict = any_fixed & any_rem &
               ((start_now != start_rem) | (fwd_fixed != fwd_rem));
    st_d.req_prev = req_now;
    st_d.start_prev = start_any;
    // Write handshake
    if (req_now && !st_q.req_prev) begin
      st_d.wr_echo = img.out_wr_id;
      st_d.status[CPA_BIT_WR_END] = 1'b1;
      if (!id_ok(img.out_wr_id)) begin
        st_d.status[CPA_BIT_WR_ERR] = 1'b1;
      end else begin
        st_d.status[CPA_BIT_WR_ERR] = 1'b0;
        if (img.out_wr_id == CPA_ID_OP_TYPE1) begin
          st_d.op_type1 = img.out_wr_data;
        end else if (img.out_wr_id == CPA_ID_POS1) begin
          st_d.pos1 = img.out_wr_data;
        end else if (is_mon_id(img.out_wr_id)) begin
          st_d.mon_addr[img.out_wr_id[1:0]] = img.out_wr_data[15:0];
        end
      end
    end else if (!req_now) begin
      // A held request keeps complete up; it drops once request is low
      st_d.status[CPA_BIT_WR_END] = 1'b0;
      st_d.status[CPA_BIT_WR_ERR] = 1'b0;
    end
    // Read path, refreshed every cycle
    st_d.rd_echo = img.out_rd_id;
    st_d.status[CPA_BIT_RD_ERR] = !id_ok(img.out_rd_id);
    if (id_ok(img.out_rd_id)) begin
      st_d.rd_data = param_rd(st_q, img.out_rd_id);
    end else begin
      st_d.rd_data = CPA_RST_ZERO32;
    end
    // Slots refresh every cycle from the stored addresses
    for (int i = 0; i < 4; i++) begin
      st_d.mon[32*i +: 32] = param_rd(st_q, st_q.mon_addr[i]);
    end
    // Motion
    st_d.energised = img.out_fixed[CPA_BIT_SERVO_ON];
    st_d.direct_run = 1'b0;
    // Losing servo-on cuts a run at once; there is no ramp down
    if (!st_d.energised) begin
      st_d.running = 1'b0;
      st_d.run_cnt = 8'h00;
    end else if (st_q.running) begin
      if (st_q.run_cnt == 8'h01) begin
        st_d.running = 1'b0;
      end
      st_d.run_cnt = st_q.run_cnt - 8'h01;
    end else if (direct_now | direct_rem) begin
      // Direct command from either word beats any start
      st_d.direct_run = 1'b1;
    end else if (start_any && !st_q.start_prev) begin
      if (conflict) begin
        st_d.fixed_out[CPA_BIT_START_ERR] = 1'b1;
      end else begin
        st_d.running = 1'b1;
        st_d.run_cnt = CPA_RUN_CYCLES;
        st_d.run_num = img.out_data_num;
        st_d.run_target = st_q.pos1;
        st_d.fixed_out[CPA_BIT_START_ERR] = 1'b0;
      end
    end
    st_d.fixed_out[CPA_BIT_MOVING] = st_d.running;
    // Ready stays low while a start is held, so the end of a run
    // cannot look like a fresh ready to a scanner still holding start
    st_d.fixed_out[CPA_BIT_READY] = st_d.energised & ~st_d.running &
                                    ~start_any;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      // Entry 1 starts absolute; slots start on their default ids
      st_q.op_type1 <= CPA_OPTYPE_ABS;
      st_q.mon_addr <= {CPA_ID_MON3, CPA_ID_MON2, CPA_ID_MON1, CPA_ID_MON0};
    end else begin
      st_q <= st_d;
    end
  end

  assign img.in_fixed = st_q.fixed_out;
  assign img.in_rd_echo = st_q.rd_echo;
  assign img.in_status = st_q.status;
  assign img.in_wr_echo = st_q.wr_echo;
  assign img.in_rd_data = st_q.rd_data;
  assign img.in_mon = st_q.mon;
  assign energised = st_q.energised;
  assign running = st_q.running;
  assign direct_run = st_q.direct_run;
  assign run_data_num = st_q.run_num;
  assign run_target = st_q.run_target;
endmodule

//--- design/cpa_scanner.sv
/*
  Scanner end: turns user requests into output-image handshakes for
  parameter write, parameter read and a stored-data start. Assumes the
  driver image is synchronous to mclk.
*/
`timescale 1ns/1ps
module cpa_scanner (
  input wire logic mclk,
  input wire logic rst_b,
  cpa_if.scanner img,
  input wire logic wr_go,
  input wire cpa_pkg::cpa_word_t wr_id,
  input wire cpa_pkg::cpa_dword_t wr_data,
  input wire cpa_pkg::cpa_word_t rd_id,
  input wire logic servo_on,
  input wire logic start_go,
  input wire cpa_pkg::cpa_word_t data_num,
  output logic wr_done,
  output logic wr_fail,
  output logic start_done,
  output cpa_pkg::cpa_dword_t rd_data,
  output logic rd_fail
);
  import cpa_pkg::*;

  typedef enum logic [2:0] {
    SC_IDLE = 3'b001,
    SC_WAIT_END = 3'b010,
    SC_WAIT_CLR = 3'b100
  } cpa_sc_e;

  typedef struct packed {
    cpa_sc_e wst;
    cpa_sc_e sst;
    cpa_word_t req;
    cpa_word_t id;
    cpa_dword_t data;
    cpa_word_t fixed;
    cpa_word_t num;
    cpa_word_t rid;
    logic wr_done;
    logic wr_fail;
    logic start_done;
    cpa_dword_t rd_data;
    logic rd_fail;
  } cpa_scn_s;

  cpa_scn_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.wr_done = 1'b0;
    st_d.start_done = 1'b0;
    st_d.rid = rd_id;
    st_d.fixed[CPA_BIT_SERVO_ON] = servo_on;
    if (img.in_rd_echo == st_q.rid) begin
      st_d.rd_data = img.in_rd_data;
      st_d.rd_fail = img.in_status[CPA_BIT_RD_ERR];
    end
    case (st_q.wst)
      SC_IDLE: begin
        if (wr_go) begin
          st_d.id = wr_id;
          st_d.data = wr_data;
          st_d.req[CPA_BIT_WR_REQ] = 1'b1;
          st_d.wst = SC_WAIT_END;
        end
      end
      SC_WAIT_END: begin
        if (img.in_status[CPA_BIT_WR_END]) begin
          st_d.req[CPA_BIT_WR_REQ] = 1'b0;
          st_d.wr_fail = img.in_status[CPA_BIT_WR_ERR];
          st_d.wst = SC_WAIT_CLR;
        end
      end
      SC_WAIT_CLR: begin
        if (!img.in_status[CPA_BIT_WR_END]) begin
          st_d.wr_done = 1'b1;
          st_d.wst = SC_IDLE;
        end
      end
      default: st_d.wst = SC_IDLE;
    endcase
    case (st_q.sst)
      SC_IDLE: begin
        if (start_go && img.in_fixed[CPA_BIT_READY]) begin
          st_d.num = data_num;
          st_d.sst = SC_WAIT_END;
        end
      end
      SC_WAIT_END: begin
        st_d.fixed[CPA_BIT_START] = 1'b1;
        st_d.sst = SC_WAIT_CLR;
      end
      SC_WAIT_CLR: begin
        if (!img.in_fixed[CPA_BIT_READY]) begin
          st_d.fixed[CPA_BIT_START] = 1'b0;
          st_d.start_done = 1'b1;
          st_d.sst = SC_IDLE;
        end
      end
      default: st_d.sst = SC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.wst <= SC_IDLE;
      st_q.sst <= SC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign img.out_data_num = st_q.num;
  assign img.out_fixed = st_q.fixed;
  assign img.out_rd_id = st_q.rid;
  assign img.out_wr_req = st_q.req;
  assign img.out_wr_id = st_q.id;
  assign img.out_wr_data = st_q.data;
  assign wr_done = st_q.wr_done;
  assign wr_fail = st_q.wr_fail;
  assign start_done = st_q.start_done;
  assign rd_data = st_q.rd_data;
  assign rd_fail = st_q.rd_fail;
endmodule

//--- pkg/cpa_if.sv
/*
  Cyclic image between the scanner end and the driver end. Assumes both
  ends share mclk; the testbench connects both modports.
*/
`timescale 1ns/1ps
interface cpa_if;
  import cpa_pkg::*;
  cpa_word_t out_data_num;
  cpa_word_t out_fixed;
  cpa_word_t out_rd_id;
  cpa_word_t out_wr_req;
  cpa_word_t out_wr_id;
  cpa_dword_t out_wr_data;
  cpa_word_t in_fixed;
  cpa_word_t in_rd_echo;
  cpa_word_t in_status;
  cpa_word_t in_wr_echo;
  cpa_dword_t in_rd_data;
  cpa_mon_t in_mon;
  modport scanner (
    output out_data_num, out_fixed, out_rd_id, out_wr_req, out_wr_id,
    output out_wr_data,
    input in_fixed, in_rd_echo, in_status, in_wr_echo, in_rd_data, in_mon
  );
  modport driver (
    input out_data_num, out_fixed, out_rd_id, out_wr_req, out_wr_id,
    input out_wr_data,
    output in_fixed, in_rd_echo, in_status, in_wr_echo, in_rd_data, in_mon
  );
endinterface

//--- pkg/cpa_pkg.sv
/*
  Constants and types shared by both ends of the cyclic parameter-access
  link. Assumes a single 25 MHz clock and active-low asynchronous reset.
*/
package cpa_pkg;
  // Byte offsets in the cyclic images
  localparam int unsigned CPA_OFS_DATA_NUM = 2;
  localparam int unsigned CPA_OFS_FIXED = 4;
  localparam int unsigned CPA_OFS_RD_ID = 30;
  localparam int unsigned CPA_OFS_WR_REQ = 32;
  localparam int unsigned CPA_OFS_WR_ID = 34;
  localparam int unsigned CPA_OFS_DATA = 36;
  localparam int unsigned CPA_OFS_MON = 40;
  // Bit positions
  localparam int unsigned CPA_BIT_WR_REQ = 0;
  localparam int unsigned CPA_BIT_WR_END = 8;
  localparam int unsigned CPA_BIT_WR_ERR = 9;
  localparam int unsigned CPA_BIT_RD_ERR = 10;
  localparam int unsigned CPA_BIT_SERVO_ON = 2;
  localparam int unsigned CPA_BIT_START = 3;
  localparam int unsigned CPA_BIT_DIRECT = 8;
  localparam int unsigned CPA_BIT_FWD = 14;
  localparam int unsigned CPA_BIT_READY = 5;
  localparam int unsigned CPA_BIT_MOVING = 13;
  localparam int unsigned CPA_BIT_START_ERR = 7;
  // Parameter identifiers
  localparam logic [15:0] CPA_ID_OP_TYPE1 = 16'h0C20;
  localparam logic [15:0] CPA_ID_POS1 = 16'h0C21;
  localparam logic [15:0] CPA_ID_MON0 = 16'h007C;
  localparam logic [15:0] CPA_ID_MON1 = 16'h007D;
  localparam logic [15:0] CPA_ID_MON2 = 16'h006D;
  localparam logic [15:0] CPA_ID_MON3 = 16'h007F;
  localparam logic [15:0] CPA_ID_MONADDR0 = 16'h0100;
  localparam logic [15:0] CPA_ID_MAX = 16'h0FFF;
  localparam logic [31:0] CPA_OPTYPE_ABS = 32'h0000_0001;
  localparam logic [15:0] CPA_RST_ZERO16 = 16'h0000;
  localparam logic [31:0] CPA_RST_ZERO32 = 32'h0000_0000;
  // Length of a positioning run, in cycles
  localparam logic [7:0] CPA_RUN_CYCLES = 8'h10;

  typedef logic [15:0] cpa_word_t;
  typedef logic [31:0] cpa_dword_t;
  typedef logic [127:0] cpa_mon_t;
endpackage

//--- tb/cpa_monitor.sv
/*
  Checker on the cyclic image between scanner and driver ends.
  Assumes tb instantiates it beside the interface, all on mclk.
*/
`timescale 1ns/1ps
module cpa_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire cpa_pkg::cpa_word_t out_fixed,
  input wire cpa_pkg::cpa_word_t out_rd_id,
  input wire cpa_pkg::cpa_word_t out_wr_req,
  input wire cpa_pkg::cpa_word_t out_wr_id,
  input wire cpa_pkg::cpa_word_t in_fixed,
  input wire cpa_pkg::cpa_word_t in_rd_echo,
  input wire cpa_pkg::cpa_word_t in_status,
  input wire cpa_pkg::cpa_word_t in_wr_echo
);
  import cpa_pkg::*;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_wr_end_rise: assert property ($rose(out_wr_req[0]) &&
    out_wr_id <= CPA_ID_MAX |=> in_status[8] &&
    in_wr_echo == $past(out_wr_id)) else $error("write end or echo missing");
  a_wr_end_hold: assert property (in_status[8] && out_wr_req[0]
    |=> in_status[8]) else $error("write end dropped early");
  a_wr_end_clear: assert property (in_status[8] && !out_wr_req[0]
    |=> !in_status[8]) else $error("write end not cleared");
  a_bad_wr_id: assert property ($rose(out_wr_req[0]) &&
    out_wr_id > CPA_ID_MAX |=> in_status[8] && in_status[9])
    else $error("failed write lacks end and error together");
  // Level request must not retrigger a store
  a_req_edge_only: assert property ($rose(in_status[8]) |->
    $past(out_wr_req[0]) && !$past(out_wr_req[0], 2))
    else $error("write end without request edge");
  a_rd_echo: assert property (1'b1 |=>
    in_rd_echo == $past(out_rd_id)) else $error("read echo wrong");
  a_rd_err_flag: assert property (1'b1 |=>
    in_status[10] == ($past(out_rd_id) > CPA_ID_MAX))
    else $error("read error flag wrong");
  a_start_ready: assert property ($rose(out_fixed[3]) |=>
    !in_fixed[5]) else $error("ready not dropped on start");
  a_run_len: assert property ($rose(in_fixed[13]) |->
    ##15 in_fixed[13] ##1 !in_fixed[13]) else $error("run length wrong");

  c_write: cover property ($rose(in_status[8]));
  c_write_err: cover property ($rose(in_status[9]));
  c_start_err: cover property ($rose(in_fixed[7]));
  c_run: cover property ($rose(in_fixed[13]));
endmodule

//--- tb/tb.sv
/*
  Bench joining scanner and driver ends through the cyclic image.
  Assumes the user-side handshakes described by the design ends.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  err_total++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); \
  end end
module tb;
  import cpa_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_go = 1'b0, servo_on = 1'b0, start_go = 1'b0;
  cpa_word_t wr_id = 16'h0000, rd_id = 16'h0000, data_num = 16'h0000;
  cpa_word_t remote_cmd = 16'h0000, run_data_num;
  cpa_dword_t wr_data = 32'h0000_0000, rd_data, run_target;
  logic wr_done, wr_fail, start_done, rd_fail, energised, running;
  logic direct_run;
  int err_total = 0;
  int check_count = 0;

  cpa_if bus ();
  cpa_scanner cpa_scanner_inst (.mclk(mclk), .rst_b(rst_b), .img(bus),
    .wr_go(wr_go), .wr_id(wr_id), .wr_data(wr_data), .rd_id(rd_id),
    .servo_on(servo_on), .start_go(start_go), .data_num(data_num),
    .wr_done(wr_done), .wr_fail(wr_fail), .start_done(start_done),
    .rd_data(rd_data), .rd_fail(rd_fail));
  cpa_driver cpa_driver_inst (.mclk(mclk), .rst_b(rst_b), .img(bus),
    .remote_cmd(remote_cmd), .energised(energised), .running(running),
    .direct_run(direct_run), .run_data_num(run_data_num),
    .run_target(run_target));
  cpa_monitor cpa_monitor_inst (.mclk(mclk), .rst_b(rst_b),
    .out_fixed(bus.out_fixed), .out_rd_id(bus.out_rd_id),
    .out_wr_req(bus.out_wr_req), .out_wr_id(bus.out_wr_id),
    .in_fixed(bus.in_fixed), .in_rd_echo(bus.in_rd_echo),
    .in_status(bus.in_status), .in_wr_echo(bus.in_wr_echo));

  always #20 mclk = ~mclk;

  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Id and data held until the next call, so stable through the handshake
  task automatic wr(input cpa_word_t id, input cpa_dword_t d);
    @(negedge mclk);
    wr_id = id;
    wr_data = d;
    wr_go = 1'b1;
    @(negedge mclk);
    wr_go = 1'b0;
    for (int i = 0; i < 40 && wr_done !== 1'b1; i++) @(negedge mclk);
    `CHK(wr_done, 1'b1)
    `CHK(bus.in_status[8], 1'b0)
    `CHK(bus.in_wr_echo, id)
  endtask

  task automatic rd(input cpa_word_t id, input cpa_dword_t e, input logic f);
    @(negedge mclk);
    rd_id = id;
    repeat (5) @(negedge mclk);
    `CHK(bus.in_rd_echo, id)
    `CHK(rd_data, e)
    `CHK(rd_fail, f)
  endtask

  // Remote word joins on the very edge the fixed start is first seen
  task automatic go(input cpa_word_t num, input cpa_word_t rem);
    @(negedge mclk);
    data_num = num;
    start_go = 1'b1;
    @(negedge mclk);
    start_go = 1'b0;
    for (int i = 0; i < 20 && bus.out_fixed[3] !== 1'b1; i++) @(negedge mclk);
    remote_cmd = rem;
    for (int i = 0; i < 20 && start_done !== 1'b1; i++) @(negedge mclk);
    `CHK(start_done, 1'b1)
  endtask

  task automatic idle;
    @(negedge mclk);
    remote_cmd = 16'h0000;
    for (int i = 0; i < 60 && bus.in_fixed[5] !== 1'b1; i++) @(negedge mclk);
    `CHK(bus.in_fixed[5], 1'b1)
  endtask

  initial begin
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    wr(CPA_ID_OP_TYPE1, CPA_OPTYPE_ABS);
    `CHK(wr_fail, 1'b0)
    wr(CPA_ID_POS1, 32'h0000_1388);
    `CHK(bus.in_mon, {32'h7F, 32'h6D, 32'h7D, 32'h7C})
    rd(CPA_ID_POS1, 32'h0000_1388, 1'b0);
    rd(CPA_ID_OP_TYPE1, CPA_OPTYPE_ABS, 1'b0);
    rd(16'h1000, 32'h0000_0000, 1'b1);
    wr(16'hF000, 32'h0000_0005);
    `CHK(wr_fail, 1'b1)
    wr(CPA_ID_MONADDR0, {16'h0000, CPA_ID_POS1});
    repeat (3) @(negedge mclk);
    `CHK(bus.in_mon[31:0], 32'h0000_1388)
    servo_on = 1'b1;
    idle();
    `CHK(energised, 1'b1)
    go(16'h0001, 16'h0000);
    `CHK(running, 1'b1)
    `CHK(run_data_num, 16'h0001)
    `CHK(run_target, 32'h0000_1388)
    idle();
    go(16'h0001, 16'h4000);
    `CHK(bus.in_fixed[7], 1'b1)
    `CHK(running, 1'b0)
    idle();
    go(16'h0001, 16'h0008);
    `CHK(running, 1'b1)
    `CHK(bus.in_fixed[7], 1'b0)
    idle();
    go(16'h0001, 16'h0108);
    `CHK(direct_run, 1'b1)
    `CHK(running, 1'b0)
    idle();
    end_sim();
  end

  // Full run is some 110 cycles; the 2500-cycle limit allows many times that
  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
